// file: shared/sysctl_pkg.sv
// constants and field layout of the system control register
// assumes a single processor clock and a synchronous active-high reset
// What this block does
// - bit 30 selects compact or fixed-width isa on kernel exception entry
// - bit 25 gives data endianness loaded on exception entry or reset
// - exception endianness fixed 0 without big-endian, 1 without little-endian
// - bit 21 mirrors hypervisor fast-interrupt bit, writes ignored
// - bit 20 makes user-writable regions execute-never for kernel fetches
// - bit 19 makes writable regions execute-never for kernel and user fetch
// - bit 18 low traps user wait-for-event that would sleep
// - bit 16 low traps user wait-for-interrupt that would sleep
// - conditional wait traps only when its condition passes
// - wait that completes early need not trap
// - bit 17 picks fault or background region for unmatched kernel access
// - unmatched user access always gives translation fault
// - bit 12 controls kernel and user instruction cacheability
// - protection off: fetches normal outer shareable, nc or write-through
// - hypervisor default-cacheable forces instruction fetches cacheable
// - bit 8 undefines endianness-setting instruction; fixed one if no mixed
// - bit 7 undefines if-then whose low nibble is not 1000
// - bit 7 undefines listed instructions following an if-then
// - those undefined cases ignore the condition check
// - if-then disable optional; absent reads zero, ignores writes
// - bit 6 ignores writes and reads an unknown value
// - bit 5 enables coprocessor barrier instructions at kernel and user
// - barrier enable optional; absent reads one, ignores writes
// - bit 2 controls kernel and user data cacheability
// - bit 1 enables alignment checks raising data abort
// - bit 0 enables the kernel protection unit
package sysctl_pkg;
  localparam int SC_TE   = 30;
  localparam int SC_EE   = 25;
  localparam int SC_FI   = 21;
  localparam int SC_USER_WRITABLE_EXEC_NEVER = 20;
  localparam int SC_WXN  = 19;
  localparam int SC_NO_TRAP_WAIT_EVENT = 18;
  localparam int SC_BR   = 17;
  localparam int SC_NO_TRAP_WAIT_INTERRUPT = 16;
  localparam int SC_ICA  = 12;
  localparam int SC_SED  = 8;
  localparam int SC_ITD  = 7;
  localparam int SC_UNK  = 6;
  localparam int SC_BEN  = 5;
  localparam int SC_DCA  = 2;
  localparam int SC_ALN  = 1;
  localparam int SC_MPU  = 0;
  // writable field mask and fixed reserved-one pattern
  localparam logic [31:0] SC_RW_MASK  = 32'h421F_11A7;
  localparam logic [31:0] SC_RES1     = 32'h30C0_0818;
  // reset image chosen for the unknown reset values
  localparam logic [31:0] SC_RESET    = 32'h0000_0000;
  // value returned by the unknown bit
  localparam logic        SC_UNK_VAL  = 1'b0;
  // attribute encodings for fetches with the protection unit off, and the if-then nibble
  localparam logic [1:0]  SC_ATTR_NC  = 2'h0;
  localparam logic [1:0]  SC_ATTR_WT  = 2'h1;
  localparam logic [1:0]  SC_SH_OUTER = 2'h2;
  localparam logic [3:0]  SC_IT_NIB   = 4'h8;
endpackage

// file: verilog/sysctl_it_check.sv
`timescale 1ns/1ps
// if-then disable decode of one halfword pair
// assumes hw fields are stable in the cycle they are checked
module sysctl_it_check (
  input  wire logic [15:0] it_hw1,   // first halfword of the if-then
  input  wire logic [15:0] next_hw1, // first halfword of the next one
  output logic             it_bad,   // if-then itself is undefined
  output logic             next_bad  // following instruction undefined
);
  import sysctl_pkg::*;
  assign it_bad = it_hw1[3:0] != SC_IT_NIB;
  always_comb begin
    next_bad = 1'b0;
    if (next_hw1[15:14] == 2'b11) next_bad = 1'b1;
    if (next_hw1[15:12] == 4'b1011) next_bad = 1'b1;
    if (next_hw1[15:11] == 5'b10100) next_bad = 1'b1;
    if (next_hw1[15:11] == 5'b01001) next_bad = 1'b1;
    if (next_hw1[15:12] == 4'b0100 && next_hw1[10]
        && next_hw1[6:3] == 4'hF) next_bad = 1'b1;
    if (next_hw1[15:10] == 6'b010001 && next_hw1[7]
        && next_hw1[2:0] == 3'h7) next_bad = 1'b1;
  end
endmodule

// file: verilog/sysctl_top.sv
`timescale 1ns/1ps
// system control register with the decode it steers
// assumes coprocessor accesses arrive as one-cycle strobes on the clock
module sysctl_top #(
  parameter bit HAS_BIG    = 1'b1, // big-endian data above user level
  parameter bit HAS_LITTLE = 1'b1, // little-endian data above user level
  parameter bit HAS_MIXED  = 1'b1, // mixed-endian supported
  parameter bit HAS_ITD    = 1'b1, // if-then disable implemented
  parameter bit HAS_BEN    = 1'b1  // barrier enable implemented
) (
  input  wire logic        clock,        // processor clock
  input  wire logic        rst,          // sync reset, active high
  input  wire logic        wr_en,        // coprocessor write strobe
  input  wire logic [31:0] wr_data,      // write data
  output logic      [31:0] rd_data,      // register read value
  input  wire logic        hyp_fast_interrupt_bit, // hypervisor copy
  input  wire logic        hyp_default_cacheable,  // forces cacheable
  input  wire logic        at_kernel,    // current level is kernel
  input  wire logic        at_user,      // current level is user
  input  wire logic        wait_event,   // wait-for-event issued
  input  wire logic        wait_irq,     // wait-for-interrupt issued
  input  wire logic        cond_pass,    // condition check passed
  input  wire logic        would_sleep,  // would not complete on its own
  input  wire logic        region_hit,   // access matched a region
  input  wire logic        user_writable,// region writable at user
  input  wire logic        writable,     // region writable
  input  wire logic        is_if_then,   // current insn is if-then
  input  wire logic        after_if_then,// current insn follows if-then
  input  wire logic [15:0] hw1,          // first halfword of current insn
  input  wire logic        is_endian_set,// endianness-setting insn
  input  wire logic        is_cp_barrier,// coprocessor barrier insn
  output logic             exception_compact_isa_select, // entry isa
  output logic             exception_endianness,  // entry endianness
  output logic             data_endianness_state, // live endianness
  input  wire logic        take_exception,        // exception entry
  output logic             wait_trap,    // trap to undefined mode
  output logic             exec_never,   // fetch forced execute-never
  output logic             mpu_fault,    // unmatched access faults
  output logic             use_background, // background attributes used
  output logic             insn_cacheable, // instruction fetch cacheable
  output logic      [1:0]  fetch_attr,   // unprotected fetch attribute
  output logic      [1:0]  fetch_share,  // unprotected fetch shareability
  output logic             data_cacheable, // data access cacheable
  output logic             align_check,  // alignment check enabled
  output logic             mpu_enable,   // protection unit enabled
  output logic             insn_undef    // instruction is undefined
);
  import sysctl_pkg::*;

  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic        end_q;
  logic        it_bad;
  logic        next_bad;
  logic        ee_eff;
  logic        sed_eff;
  logic        itd_eff;
  logic        ben_eff;

  sysctl_it_check u_it (
    .it_hw1   (hw1),
    .next_hw1 (hw1),
    .it_bad   (it_bad),
    .next_bad (next_bad)
  );

  // reserved bits never stored, fixed bits never written
  always_comb begin
    ctl_d = ctl_q;
    if (wr_en) ctl_d = wr_data & SC_RW_MASK;
  end

  always_ff @(posedge clock) begin
    if (rst) ctl_q <= SC_RESET;
    else     ctl_q <= ctl_d;
  end

  // fixed values replace stored ones when a feature is absent
  always_comb begin
    ee_eff = ctl_q[SC_EE];
    if (!HAS_BIG)    ee_eff = 1'b0;
    if (!HAS_LITTLE) ee_eff = 1'b1;
    sed_eff = HAS_MIXED ? ctl_q[SC_SED] : 1'b1;
    itd_eff = HAS_ITD ? ctl_q[SC_ITD] : 1'b0;
    ben_eff = HAS_BEN ? ctl_q[SC_BEN] : 1'b1;
  end

  always_comb begin
    rd_data = SC_RES1 | (ctl_q & SC_RW_MASK);
    rd_data[SC_EE]  = ee_eff;
    rd_data[SC_FI]  = hyp_fast_interrupt_bit;
    rd_data[SC_SED] = sed_eff;
    rd_data[SC_ITD] = itd_eff;
    rd_data[SC_UNK] = SC_UNK_VAL;
    rd_data[SC_BEN] = ben_eff;
  end

  always_ff @(posedge clock) begin
    // reset loads the entry endianness of the reset image
    if (rst)                 end_q <= HAS_LITTLE ?
                                      (HAS_BIG && SC_RESET[SC_EE]) : 1'b1;
    else if (take_exception) end_q <= ee_eff;
  end
  assign data_endianness_state = end_q;

  assign exception_compact_isa_select = ctl_q[SC_TE];
  assign exception_endianness         = ee_eff;

  // only waits that truly sleep and pass their condition trap
  assign wait_trap = at_user && cond_pass && would_sleep
    && ((wait_event && !ctl_q[SC_NO_TRAP_WAIT_EVENT])
     || (wait_irq   && !ctl_q[SC_NO_TRAP_WAIT_INTERRUPT]));

  assign exec_never =
      (at_kernel && ctl_q[SC_USER_WRITABLE_EXEC_NEVER] && user_writable)
   || ((at_kernel || at_user) && ctl_q[SC_WXN] && writable);

  assign mpu_enable = ctl_q[SC_MPU];
  assign use_background = ctl_q[SC_MPU] && !region_hit && at_kernel
    && ctl_q[SC_BR];
  assign mpu_fault = ctl_q[SC_MPU] && !region_hit
    && (at_user || (at_kernel && !ctl_q[SC_BR]));

  assign insn_cacheable = ctl_q[SC_ICA] || hyp_default_cacheable;
  assign fetch_attr  = ctl_q[SC_ICA] ? SC_ATTR_WT : SC_ATTR_NC;
  assign fetch_share = SC_SH_OUTER;
  assign data_cacheable = ctl_q[SC_DCA] || hyp_default_cacheable;
  assign align_check = ctl_q[SC_ALN];

  // undefined regardless of the condition check
  assign insn_undef = (at_kernel || at_user) && (
      (is_endian_set && sed_eff)
   || (itd_eff && is_if_then && it_bad)
   || (itd_eff && after_if_then && next_bad)
   || (is_cp_barrier && !ben_eff));
endmodule

// file: tb/sysctl_properties.sv
// concurrent checks on the ports of sysctl_top
// assumes default parameters; bound into every sysctl_top
`timescale 1ns/1ps
module sysctl_properties
  import sysctl_pkg::*;
(
  input wire logic        clock,                  // processor clock
  input wire logic        rst,                    // sync reset
  input wire logic        wr_en,                  // write strobe
  input wire logic        take_exception,         // exception entry
  input wire logic [31:0] wr_data,                // write value
  input wire logic [31:0] rd_data,                // read value
  input wire logic        hyp_fast_interrupt_bit, // hypervisor copy
  input wire logic        hyp_default_cacheable,  // forces cacheable
  input wire logic        at_kernel,              // kernel level
  input wire logic        at_user,                // user level
  input wire logic        wait_event,             // wait-for-event
  input wire logic        wait_irq,               // wait-for-interrupt
  input wire logic        cond_pass,              // condition passed
  input wire logic        would_sleep,            // would sleep
  input wire logic        region_hit,             // region matched
  input wire logic        user_writable,          // user writable
  input wire logic        writable,               // writable
  input wire logic        is_endian_set,          // endian-set insn
  input wire logic        data_endianness_state,  // live endianness
  input wire logic        wait_trap,              // wait trap
  input wire logic        exec_never,             // execute-never
  input wire logic        mpu_fault,              // protection fault
  input wire logic        use_background,         // background used
  input wire logic        insn_cacheable,         // fetch cacheable
  input wire logic        data_cacheable,         // data cacheable
  input wire logic        insn_undef,             // undefined insn
  input wire logic [1:0]  fetch_attr,             // fetch attribute
  input wire logic [1:0]  fetch_share             // fetch shareability
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_write_store: assert property (
    wr_en |=> (rd_data & SC_RW_MASK) == ($past(wr_data) & SC_RW_MASK))
    else $error("write value not stored");
  a_fixed_bits: assert property (
    (rd_data & ~(SC_RW_MASK | 32'h0020_0000)) == SC_RES1)
    else $error("fixed bits wrong");
  a_fi_mirror: assert property (
    rd_data[21] == hyp_fast_interrupt_bit) else $error("mirror wrong");
  a_wait_trap: assert property (wait_trap == (at_user && cond_pass &&
    would_sleep && ((wait_event && !rd_data[18]) ||
    (wait_irq && !rd_data[16])))) else $error("wait trap wrong");
  a_exec_never: assert property (exec_never == ((at_kernel &&
    user_writable && rd_data[20]) || ((at_kernel || at_user) &&
    writable && rd_data[19]))) else $error("execute-never wrong");
  a_mpu_fault: assert property (mpu_fault == (rd_data[0] &&
    !region_hit && ((at_kernel && !rd_data[17]) || at_user)))
    else $error("protection fault wrong");
  a_background_use: assert property (at_kernel |->
    use_background == (rd_data[0] && !region_hit && rd_data[17]))
    else $error("background use wrong");
  a_cache_force: assert property (
    insn_cacheable == (rd_data[12] || hyp_default_cacheable) &&
    data_cacheable == (rd_data[2] || hyp_default_cacheable))
    else $error("cacheability wrong");
  a_fetch_attr: assert property (!rd_data[0] |-> fetch_share ==
    SC_SH_OUTER && fetch_attr == (rd_data[12] ? SC_ATTR_WT : SC_ATTR_NC))
    else $error("fetch attribute wrong");
  a_entry_endian: assert property (
    take_exception |=> data_endianness_state == $past(rd_data[25]))
    else $error("entry endianness wrong");
  a_endian_undef: assert property (
    is_endian_set && at_kernel && rd_data[8] |-> insn_undef)
    else $error("endian set not undefined");
endmodule
bind sysctl_top sysctl_properties i_chk (.*);

// file: tb/system_control_register_test.sv
// directed bench for sysctl_top, one task per scenario
// assumes default parameters and a 200 MHz clock
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module system_control_register_test;
  import sysctl_pkg::*;
  localparam logic [12:0] K = 13'h0001, U = 13'h0002, E = 13'h0004,
    I = 13'h0008, C = 13'h0010, S = 13'h0020, H = 13'h0040, W = 13'h0080,
    A = 13'h0100, T = 13'h0200, F = 13'h0400, N = 13'h0800, X = 13'h1000;
  logic        clock = 0, rst = 1, wr_en = 0, is_cp_barrier = 0;
  logic        hyp_fast_interrupt_bit = 0, hyp_default_cacheable = 0;
  logic [12:0] lv = '0;
  logic [15:0] hw1 = '0;
  logic [31:0] wr_data = '0, rd_data;
  logic [1:0]  fetch_attr, fetch_share;
  logic        exception_compact_isa_select, exception_endianness, wait_trap;
  logic        data_endianness_state, exec_never, mpu_fault, use_background;
  logic        insn_cacheable, data_cacheable, align_check, mpu_enable;
  logic        insn_undef;
  wire logic   at_kernel, at_user, wait_event, wait_irq, cond_pass;
  wire logic   would_sleep, region_hit, user_writable, writable, is_if_then;
  wire logic   after_if_then, is_endian_set, take_exception;
  int          checked = 0, err_count = 0;
  assign {take_exception, is_endian_set, after_if_then, is_if_then, writable,
    user_writable, region_hit, would_sleep, cond_pass, wait_irq, wait_event,
    at_user, at_kernel} = lv;
  wire logic [6:0] cache_v = {insn_cacheable, data_cacheable, fetch_attr,
    fetch_share, align_check};
  sysctl_top i_dut (.*);
  initial forever #2.5 clock = ~clock;
  task wr(input logic [31:0] d, input logic f = 1'b0);
    @(posedge clock);
    wr_en <= 1;
    wr_data <= d;
    hyp_fast_interrupt_bit <= f;
    @(posedge clock);
    wr_en <= 0;
    #1;
  endtask
  task set(input logic [12:0] v, input logic [15:0] h = '0,
           input logic d = 0, input logic b = 0);
    @(posedge clock);
    lv <= v;
    hw1 <= h;
    hyp_default_cacheable <= d;
    is_cp_barrier <= b;
    #1;
  endtask
  task t_regs;
    `CHK("reset", SC_RES1, rd_data)
    wr(32'hFFFF_FFFF);
    `CHK("ones", 32'h72DF_19BF, rd_data)
    @(posedge clock);
    rst <= 1;
    @(posedge clock);
    rst <= 0;
    #1;
    `CHK("rereset", SC_RES1, rd_data)
    wr(32'h0000_0000, 1'b1);
    `CHK("mirror", 32'h30E0_0818, rd_data)
    $display("t_regs done");
  endtask
  task t_wait;
    set(U|E|C|S);
    `CHK("wfe", 1'b1, wait_trap)
    set(U|E|S);
    `CHK("cond", 1'b0, wait_trap)
    set(U|I|C);
    `CHK("early", 1'b0, wait_trap)
    set(U|I|C|S);
    `CHK("wfi", 1'b1, wait_trap)
    wr(32'h0005_0000);
    `CHK("no trap", 1'b0, wait_trap)
    $display("t_wait done");
  endtask
  task t_xn;
    wr(32'h0010_0000);
    set(K|W);
    `CHK("user_writable_exec_never", 1'b1, exec_never)
    set(U|A);
    `CHK("wxn off", 1'b0, exec_never)
    wr(32'h0008_0000);
    `CHK("wxn", 1'b1, exec_never)
    $display("t_xn done");
  endtask
  task t_mpu;
    wr(32'h0000_0001);
    set(K);
    `CHK("fault", 2'b10, {mpu_fault, use_background})
    `CHK("mpu en", 1'b1, mpu_enable)
    wr(32'h0002_0001);
    `CHK("bg", 2'b01, {mpu_fault, use_background})
    set(U);
    `CHK("user", 2'b10, {mpu_fault, use_background})
    $display("t_mpu done");
  endtask
  task t_cache;
    wr(32'h0000_0000);
    `CHK("nc", 6'h02, cache_v[6:1])
    set(K, '0, 1'b1);
    `CHK("dc", 6'h32, cache_v[6:1])
    wr(32'h0000_1006);
    set(K);
    `CHK("wt", 7'h6D, cache_v)
    $display("t_cache done");
  endtask
  task t_undef;
    wr(32'h0000_0180);
    set(K|N);
    `CHK("endset", 1'b1, insn_undef)
    set(K|T, 16'hBF08);
    `CHK("it ok", 1'b0, insn_undef)
    set(K|T, 16'hBF04);
    `CHK("it bad", 1'b1, insn_undef)
    set(K|F, 16'hB000);
    `CHK("misc", 1'b1, insn_undef)
    set(K|F|C, 16'h4800);
    `CHK("pcrel", 1'b1, insn_undef)
    set(K, '0, 1'b0, 1'b1);
    `CHK("barrier off", 1'b1, insn_undef)
    wr(32'h0000_0020);
    `CHK("barrier on", 1'b0, insn_undef)
    $display("t_undef done");
  endtask
  task t_exc;
    wr(32'h4200_0000);
    set(X);
    set('0);
    `CHK("entry", 2'b11, {exception_compact_isa_select,
      data_endianness_state})
    `CHK("ee", 1'b1, exception_endianness)
    $display("t_exc done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 0;
    #1;
    t_regs();
    t_wait();
    t_xn();
    t_mpu();
    t_cache();
    t_undef();
    t_exc();
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
